//--- pkg/cpr_pkg.sv
package cpr_pkg;

   // data widths
   localparam int RAW_W  = 10;
   localparam int PIX_W  = 16;
   localparam int ADDR_W = 32;
   localparam int RA_W   = 8;

   // register byte offsets
   localparam logic [RA_W-1:0] OFF_CTRL      = 8'h00;
   localparam logic [RA_W-1:0] OFF_RATIO     = 8'h04;
   localparam logic [RA_W-1:0] OFF_MEM_IN    = 8'h08;
   localparam logic [RA_W-1:0] OFF_IN_SIZE   = 8'h0C;
   localparam logic [RA_W-1:0] OFF_OUT_BASE  = 8'h10;
   localparam logic [RA_W-1:0] OFF_STRIDE    = 8'h14;
   localparam logic [RA_W-1:0] OFF_BUF_COUNT = 8'h18;
   localparam logic [RA_W-1:0] OFF_STATUS    = 8'h1C;
   localparam logic [RA_W-1:0] OFF_IRQ_STAT  = 8'h20;
   localparam logic [RA_W-1:0] OFF_IRQ_MASK  = 8'h24;

   // control register fields
   localparam int CTL_VIDEO_PORT_ENABLE  = 0;
   localparam int CTL_RAW_MEM_WRITE      = 1;
   localparam int CTL_MEM_TO_RSZ_SELECT  = 2;
   localparam int CTL_PIPELINE_SOURCE    = 3;
   localparam int CTL_PIPE_TO_RSZ_PORT   = 4;
   localparam int CTL_PIPE_TO_MEM_PORT   = 5;
   localparam int CTL_RSZ_INPUT_SOURCE   = 6;
   localparam int CTL_HIST_SOURCE        = 7;
   localparam int CTL_RSZ_ENABLE         = 8;
   localparam int CTL_TWO_PASS           = 9;
   localparam int CTL_W                  = 10;
   localparam logic [CTL_W-1:0] CTRL_RESET = 10'h000;

   // resize ratio field: 256 means 1:1; 64 is 4x up, 1024 is 1/4 down
   localparam int RATIO_W = 11;
   localparam logic [RATIO_W-1:0] RATIO_RESET = 11'h100;
   localparam logic [RATIO_W-1:0] RATIO_MIN   = 11'h040;
   localparam logic [RATIO_W-1:0] RATIO_MAX   = 11'h400;

   localparam int SIZE_W = 16;
   localparam int BUF_W  = 4;
   localparam logic [BUF_W-1:0] BUF_COUNT_RESET = 4'h1;

   // status fields
   localparam int ST_FRAME_ACTIVE = 0;
   localparam int ST_RSZ_BUSY     = 1;
   localparam int ST_PASS         = 2;
   localparam int ST_BUF_LSB      = 4;

   // interrupt events
   localparam int IRQ_W         = 4;
   localparam int IRQ_PIPE_EOF  = 0;
   localparam int IRQ_RSZ_EOF   = 1;
   localparam int IRQ_RATIO_ERR = 2;
   localparam int IRQ_MEM_DONE  = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

   // memory read pacing: one request per two dma clock cycles
   localparam logic [1:0] MRD_PACE = 2'h2;
   localparam logic [ADDR_W-1:0] PIX_BYTES = 32'h0000_0002;
   localparam logic [7:0] CHROMA_MID = 8'h80;

   typedef enum logic [1:0] {
      RSZ_IDLE  = 2'b00,
      RSZ_MEM   = 2'b01,
      RSZ_DRAIN = 2'b11,
      RSZ_LIVE  = 2'b10
   } cpr_rsz_state_t;

endpackage : cpr_pkg

//--- hdl/cpr_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser; output follows only once stages two and three agree
module cpr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // asynchronous input and clean output
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s1  <= '0;
         s2  <= '0;
         s3  <= '0;
         q_o <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_o <= s3;
         end
      end
   end

endmodule : cpr_sync

//--- hdl/cpr_router.sv
`timescale 1ns/1ns
module cpr_router
   import cpr_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // register port
   input  wire logic [RA_W-1:0]   reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_we_i,
   input  wire logic              reg_re_i,
   output logic      [31:0]       reg_rdata_o,
   // sensor pins
   input  wire logic [RAW_W-1:0]  sen_data_i,
   input  wire logic              sen_valid_i,
   input  wire logic              sen_frame_i,
   // raw fan-out
   output logic      [RAW_W-1:0]  stats_data_o,
   output logic                   stats_valid_o,
   output logic      [RAW_W-1:0]  hist_data_o,
   output logic                   hist_valid_o,
   output logic      [PIX_W-1:0]  pipe_data_o,
   output logic                   pipe_valid_o,
   // resizer port
   output logic      [PIX_W-1:0]  rsz_in_data_o,
   output logic                   rsz_in_valid_o,
   input  wire logic [PIX_W-1:0]  rsz_out_data_i,
   input  wire logic              rsz_out_valid_i,
   input  wire logic              rsz_eof_i,
   // memory read
   output logic                   mrd_req_o,
   output logic      [ADDR_W-1:0] mrd_addr_o,
   input  wire logic [PIX_W-1:0]  mrd_data_i,
   input  wire logic              mrd_valid_i,
   // memory write
   output logic                   mwr_valid_o,
   output logic      [ADDR_W-1:0] mwr_addr_o,
   output logic      [PIX_W-1:0]  mwr_data_o,
   // interrupt
   output logic                   irq_o
);

   logic [CTL_W-1:0]   ctrl;
   logic [RATIO_W-1:0] ratio;
   logic [ADDR_W-1:0]  mem_in_addr;
   logic [SIZE_W-1:0]  in_size;
   logic [ADDR_W-1:0]  out_base;
   logic [ADDR_W-1:0]  stride;
   logic [BUF_W-1:0]   buf_count;
   logic [BUF_W-1:0]   buf_index;
   logic [IRQ_W-1:0]   irq_stat;
   logic [IRQ_W-1:0]   irq_mask;
   logic [IRQ_W-1:0]   irq_event;
   logic               pass;

   // synchronised sensor pins
   logic [RAW_W+1:0]   sen_sync;
   logic [RAW_W-1:0]   raw;
   logic               raw_valid;
   logic               frame;
   logic               frame_d;
   logic               valid_d;
   logic               pipe_eof;

   cpr_sync #(
      .W (RAW_W + 2)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({sen_frame_i, sen_valid_i, sen_data_i}),
      .q_o     (sen_sync)
   );

   assign raw       = sen_sync[RAW_W-1:0];
   // the filter passes only valid pulses of two cycles or more, so a sample is taken on its rise
   assign raw_valid = sen_sync[RAW_W] & ~valid_d & sen_sync[RAW_W+1]
                      & ctrl[CTL_VIDEO_PORT_ENABLE];
   assign frame     = sen_sync[RAW_W+1];
   assign pipe_eof  = frame_d & ~frame;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         frame_d <= 1'b0;
         valid_d <= 1'b0;
      end else begin
         frame_d <= frame;
         valid_d <= sen_sync[RAW_W];
      end
   end

   // raw fan-out to statistics and histogram
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stats_data_o  <= '0;
         stats_valid_o <= 1'b0;
         hist_data_o   <= '0;
         hist_valid_o  <= 1'b0;
      end else begin
         stats_data_o  <= raw;
         stats_valid_o <= raw_valid;
         hist_data_o   <= raw;
         // histogram source 1 means memory input, so live data is withheld
         hist_valid_o  <= raw_valid & ~ctrl[CTL_HIST_SOURCE];
      end
   end

   // pipeline: luma from the sample, chroma CHROMA_MID plus the top bits of its difference to the previous sample
   logic             chroma_sel;
   logic [RAW_W-1:0] raw_prev;
   logic [RAW_W:0]   diff;
   logic             pipe_in_valid;
   logic [PIX_W-1:0] next_pipe_word;

   assign pipe_in_valid  = raw_valid & ~ctrl[CTL_PIPELINE_SOURCE];
   assign diff           = {1'b0, raw} - {1'b0, raw_prev};
   assign next_pipe_word = {CHROMA_MID + diff[RAW_W:RAW_W-7], raw[RAW_W-1:2]};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         chroma_sel   <= 1'b0;
         raw_prev     <= '0;
         pipe_data_o  <= '0;
         pipe_valid_o <= 1'b0;
      end else begin
         pipe_valid_o <= pipe_in_valid;
         if (pipe_in_valid) begin
            pipe_data_o <= next_pipe_word;
            raw_prev    <= raw;
            chroma_sel  <= ~chroma_sel;
         end
         if (pipe_eof) begin
            chroma_sel <= 1'b0;
         end
      end
   end

   // resizer input routing and memory reader
   cpr_rsz_state_t   rsz_state;
   logic [SIZE_W-1:0] rd_left;
   logic [1:0]        pace;
   logic              ratio_ok;
   logic              rsz_start;
   logic              ratio_err;
   logic              mem_done;

   assign ratio_ok  = (ratio >= RATIO_MIN) && (ratio <= RATIO_MAX);
   assign rsz_start = ctrl[CTL_RSZ_ENABLE] && rsz_state == RSZ_IDLE;
   assign ratio_err = rsz_start && !ratio_ok;
   assign mem_done  = rsz_state == RSZ_MEM && rd_left == '0;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rsz_state  <= RSZ_IDLE;
         rd_left    <= '0;
         pace       <= '0;
         mrd_req_o  <= 1'b0;
         mrd_addr_o <= '0;
      end else begin
         mrd_req_o <= 1'b0;
         case (rsz_state)
            RSZ_IDLE: begin
               if (rsz_start && ratio_ok) begin
                  if (ctrl[CTL_RSZ_INPUT_SOURCE]) begin
                     rsz_state  <= RSZ_MEM;
                     rd_left    <= in_size;
                     mrd_addr_o <= mem_in_addr;
                     pace       <= '0;
                  end else begin
                     rsz_state <= RSZ_LIVE;
                  end
               end
            end
            RSZ_MEM: begin
               if (rd_left == '0) begin
                  rsz_state <= RSZ_DRAIN;
               end else if (pace == '0) begin
                  mrd_req_o <= 1'b1;
                  pace      <= MRD_PACE - 2'h1;
                  rd_left   <= rd_left - 16'h0001;
               end else begin
                  pace <= pace - 2'h1;
                  if (pace == 2'h1) begin
                     mrd_addr_o <= mrd_addr_o + PIX_BYTES;
                  end
               end
            end
            RSZ_DRAIN, RSZ_LIVE: begin
               if (rsz_eof_i) begin
                  rsz_state <= RSZ_IDLE;
               end
            end
            default: begin
               rsz_state <= RSZ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rsz_in_data_o  <= '0;
         rsz_in_valid_o <= 1'b0;
      end else if (rsz_state == RSZ_LIVE) begin
         // live pass never reads external memory
         rsz_in_data_o  <= next_pipe_word;
         rsz_in_valid_o <= pipe_in_valid & ctrl[CTL_PIPE_TO_RSZ_PORT];
      end else if (rsz_state == RSZ_MEM || rsz_state == RSZ_DRAIN) begin
         rsz_in_data_o  <= mrd_data_i;
         rsz_in_valid_o <= mrd_valid_i;
      end else begin
         rsz_in_valid_o <= 1'b0;
      end
   end

   // pass tracking for two-pass zoom
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pass <= 1'b0;
      end else if (!ctrl[CTL_TWO_PASS]) begin
         pass <= 1'b0;
      end else if (rsz_eof_i && rsz_state != RSZ_IDLE) begin
         pass <= ~pass;
      end
   end

   // frame writer into circular buffers
   logic             wr_valid;
   logic [PIX_W-1:0] wr_data;
   logic             wr_eof;
   logic [ADDR_W-1:0] wr_offset;
   logic [ADDR_W-1:0] buf_addr;

   always_comb begin
      if (ctrl[CTL_RAW_MEM_WRITE]) begin
         wr_valid = raw_valid;
         wr_data  = {{(PIX_W-RAW_W){1'b0}}, raw};
         wr_eof   = pipe_eof;
      end else if (ctrl[CTL_PIPE_TO_MEM_PORT]) begin
         wr_valid = pipe_in_valid;
         wr_data  = next_pipe_word;
         wr_eof   = pipe_eof;
      end else begin
         wr_valid = rsz_out_valid_i;
         wr_data  = rsz_out_data_i;
         wr_eof   = rsz_eof_i;
      end
   end

   // a product wider than 32 bits is cut on purpose; buffers live below 4 GiB
   assign buf_addr = out_base + ADDR_W'(stride * {{(ADDR_W-BUF_W){1'b0}}, buf_index});

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         buf_index   <= '0;
         wr_offset   <= '0;
         mwr_valid_o <= 1'b0;
         mwr_addr_o  <= '0;
         mwr_data_o  <= '0;
      end else begin
         mwr_valid_o <= wr_valid;
         mwr_data_o  <= wr_data;
         mwr_addr_o  <= buf_addr + wr_offset;
         if (wr_eof) begin
            wr_offset <= '0;
            if (buf_index + 4'h1 >= buf_count) begin
               buf_index <= '0;
            end else begin
               buf_index <= buf_index + 4'h1;
            end
         end else if (wr_valid) begin
            wr_offset <= wr_offset + PIX_BYTES;
         end
      end
   end

   // interrupts: set wins over the write-one-to-clear
   assign irq_event[IRQ_PIPE_EOF]  = pipe_eof;
   assign irq_event[IRQ_RSZ_EOF]   = rsz_eof_i && rsz_state != RSZ_IDLE;
   assign irq_event[IRQ_RATIO_ERR] = ratio_err;
   assign irq_event[IRQ_MEM_DONE]  = mem_done;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_stat <= IRQ_RESET;
      end else begin
         if (reg_we_i && reg_addr_i == OFF_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~reg_wdata_i[IRQ_W-1:0]) | irq_event;
         end else begin
            irq_stat <= irq_stat | irq_event;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // register writes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl        <= CTRL_RESET;
         ratio       <= RATIO_RESET;
         mem_in_addr <= '0;
         in_size     <= '0;
         out_base    <= '0;
         stride      <= '0;
         buf_count   <= BUF_COUNT_RESET;
         irq_mask    <= IRQ_RESET;
      end else begin
         // enable is one-shot: it drops when the pass ends or is refused
         if (irq_event[IRQ_RSZ_EOF] || ratio_err) begin
            ctrl[CTL_RSZ_ENABLE] <= 1'b0;
         end
         if (reg_we_i) begin
            case (reg_addr_i)
               OFF_CTRL:      ctrl        <= reg_wdata_i[CTL_W-1:0];
               OFF_RATIO:     ratio       <= reg_wdata_i[RATIO_W-1:0];
               OFF_MEM_IN:    mem_in_addr <= reg_wdata_i;
               OFF_IN_SIZE:   in_size     <= reg_wdata_i[SIZE_W-1:0];
               OFF_OUT_BASE:  out_base    <= reg_wdata_i;
               OFF_STRIDE:    stride      <= reg_wdata_i;
               OFF_BUF_COUNT: buf_count   <= reg_wdata_i[BUF_W-1:0];
               OFF_IRQ_MASK:  irq_mask    <= reg_wdata_i[IRQ_W-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_re_i) begin
         case (reg_addr_i)
            OFF_CTRL:      reg_rdata_o <= 32'(ctrl);
            OFF_RATIO:     reg_rdata_o <= 32'(ratio);
            OFF_MEM_IN:    reg_rdata_o <= mem_in_addr;
            OFF_IN_SIZE:   reg_rdata_o <= 32'(in_size);
            OFF_OUT_BASE:  reg_rdata_o <= out_base;
            OFF_STRIDE:    reg_rdata_o <= stride;
            OFF_BUF_COUNT: reg_rdata_o <= 32'(buf_count);
            OFF_STATUS: begin
               reg_rdata_o                  <= '0;
               reg_rdata_o[ST_FRAME_ACTIVE] <= frame;
               reg_rdata_o[ST_RSZ_BUSY]     <= rsz_state != RSZ_IDLE;
               reg_rdata_o[ST_PASS]         <= pass;
               reg_rdata_o[ST_BUF_LSB+:BUF_W] <= buf_index;
            end
            OFF_IRQ_STAT:  reg_rdata_o <= 32'(irq_stat);
            OFF_IRQ_MASK:  reg_rdata_o <= 32'(irq_mask);
            default:       reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

endmodule : cpr_router

//--- verification/cpr_router_properties.sv
`timescale 1ns/1ns
module cpr_router_props
   import cpr_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // raw fan-out
   input  wire logic [RAW_W-1:0]  stats_data_o,
   input  wire logic              stats_valid_o,
   input  wire logic [RAW_W-1:0]  hist_data_o,
   input  wire logic              hist_valid_o,
   input  wire logic [PIX_W-1:0]  pipe_data_o,
   input  wire logic              pipe_valid_o,
   // resizer and memory
   input  wire logic [PIX_W-1:0]  rsz_in_data_o,
   input  wire logic              rsz_in_valid_o,
   input  wire logic              mrd_req_o,
   input  wire logic [ADDR_W-1:0] mrd_addr_o,
   input  wire logic [PIX_W-1:0]  mrd_data_i,
   input  wire logic              mrd_valid_i,
   input  wire logic              mwr_valid_o,
   input  wire logic [ADDR_W-1:0] mwr_addr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_hist_with_stats: assert property (
      hist_valid_o |-> stats_valid_o && hist_data_o == stats_data_o)
      else $error("histogram sample differs from statistics sample");
   a_pipe_with_stats: assert property (
      stats_valid_o |-> pipe_valid_o)
      else $error("statistics sample without pipeline word");
   a_luma_from_raw: assert property (
      pipe_valid_o |-> pipe_data_o[7:0] == stats_data_o[9:2])
      else $error("luma does not follow raw sample");
   a_live_forward: assert property (
      rsz_in_valid_o && !$past(mrd_valid_i) |-> pipe_valid_o && rsz_in_data_o == pipe_data_o)
      else $error("live resizer word differs from pipeline word");
   a_mem_forward: assert property (
      mrd_valid_i |=> rsz_in_valid_o && rsz_in_data_o == $past(mrd_data_i))
      else $error("memory word not forwarded to resizer");
   a_req_half_rate: assert property (
      mrd_req_o |=> !mrd_req_o)
      else $error("memory requests closer than two cycles");
   a_req_addr_step: assert property (
      mrd_req_o ##2 mrd_req_o |-> mrd_addr_o == $past(mrd_addr_o, 2) + PIX_BYTES)
      else $error("memory read address step wrong");
   a_write_addr_step: assert property (
      mwr_valid_o ##1 mwr_valid_o |-> mwr_addr_o == $past(mwr_addr_o) + PIX_BYTES)
      else $error("write address step wrong");

   c_mem_pass: cover property (mrd_req_o ##2 mrd_req_o);
   c_live_word: cover property (rsz_in_valid_o && pipe_valid_o);
   c_write_burst: cover property (mwr_valid_o ##1 mwr_valid_o);
endmodule : cpr_router_props

//--- verification/cpr_far_model.sv
`timescale 1ns/1ns
module cpr_far_model
   import cpr_pkg::*;
(
   // clock and pacing
   input  wire logic              clk_i,
   input  wire logic              slow_i,
   // memory read side
   input  wire logic              mrd_req_i,
   input  wire logic [ADDR_W-1:0] mrd_addr_i,
   output logic      [PIX_W-1:0]  mrd_data_o,
   output logic                   mrd_valid_o,
   // sensor pins
   output logic      [RAW_W-1:0]  sen_data_o,
   output logic                   sen_valid_o,
   output logic                   sen_frame_o
);
   logic             r1 = 1'b0;
   logic             r2 = 1'b0;
   logic [PIX_W-1:0] a1 = '0;
   logic [PIX_W-1:0] a2 = '0;

   initial begin
      mrd_data_o = '0;
      mrd_valid_o = 1'b0;
      sen_data_o = '0;
      sen_valid_o = 1'b0;
      sen_frame_o = 1'b0;
   end

   // returns the low address bits; idle data is inverted so stale words never look valid
   always @(posedge clk_i) begin
      r1 <= mrd_req_i;
      a1 <= mrd_addr_i[PIX_W-1:0];
      r2 <= r1;
      a2 <= a1;
      mrd_valid_o <= slow_i ? r2 : r1;
      mrd_data_o <= (slow_i ? r2 : r1) ? (slow_i ? a2 : a1) : ~mrd_data_o;
   end

   task automatic send_frame(input logic [RAW_W-1:0] base, input int n);
      int i;
      // every pin phase lasts at least two cycles so that the input filter lets it through
      @(posedge clk_i);
      sen_frame_o <= 1'b1;
      @(posedge clk_i);
      for (i = 0; i < n; i++) begin
         @(posedge clk_i);
         sen_valid_o <= 1'b1;
         sen_data_o <= base + RAW_W'(7 * i);
         @(posedge clk_i);
         @(posedge clk_i);
         sen_valid_o <= 1'b0;
         sen_data_o <= ~sen_data_o;
         @(posedge clk_i);
      end
      @(posedge clk_i);
      sen_frame_o <= 1'b0;
   endtask : send_frame
endmodule : cpr_far_model

//--- verification/test_cpr_router.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_cpr_router
   import cpr_pkg::*;
;
   logic clk_i = 1'b0, rst_n_i = 1'b0, we = 1'b0, re = 1'b0, slow = 1'b0;
   logic [RA_W-1:0] addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [RAW_W-1:0] sen_data, stats_data, hist_data, last_hist;
   logic sen_valid, sen_frame, stats_valid, hist_valid, pipe_valid, rin_valid, irq;
   logic [PIX_W-1:0] pipe_data, rin_data, mrd_data, last_pipe;
   logic [PIX_W-1:0] rout_data = '0;
   logic rout_valid = 1'b0, rsz_eof = 1'b0, mrd_valid, mrd_req, mwr_valid;
   logic [ADDR_W-1:0] mrd_addr, mwr_addr, first_req, wr_a[2];
   logic [PIX_W-1:0] mwr_data;
   int errors = 0, checks_done = 0, n_st, n_hi, n_pi, n_ri, n_rq, n_wr;

   always #5 clk_i = ~clk_i;

   cpr_router dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .sen_data_i(sen_data),
      .sen_valid_i(sen_valid), .sen_frame_i(sen_frame), .stats_data_o(stats_data),
      .stats_valid_o(stats_valid), .hist_data_o(hist_data), .hist_valid_o(hist_valid),
      .pipe_data_o(pipe_data), .pipe_valid_o(pipe_valid), .rsz_in_data_o(rin_data),
      .rsz_in_valid_o(rin_valid), .rsz_out_data_i(rout_data), .rsz_out_valid_i(rout_valid),
      .rsz_eof_i(rsz_eof), .mrd_req_o(mrd_req), .mrd_addr_o(mrd_addr), .mrd_data_i(mrd_data),
      .mrd_valid_i(mrd_valid), .mwr_valid_o(mwr_valid), .mwr_addr_o(mwr_addr),
      .mwr_data_o(mwr_data), .irq_o(irq));

   cpr_far_model far_u (.clk_i(clk_i), .slow_i(slow), .mrd_req_i(mrd_req), .mrd_addr_i(mrd_addr),
      .mrd_data_o(mrd_data), .mrd_valid_o(mrd_valid), .sen_data_o(sen_data),
      .sen_valid_o(sen_valid), .sen_frame_o(sen_frame));

   always @(posedge clk_i) begin
      if (stats_valid) n_st++;
      if (hist_valid) begin n_hi++; last_hist = hist_data; end
      if (pipe_valid) begin n_pi++; last_pipe = pipe_data; end
      if (rin_valid) n_ri++;
      if (mrd_req) begin if (n_rq == 0) first_req = mrd_addr; n_rq++; end
      if (mwr_valid) begin if (n_wr < 2) wr_a[n_wr] = mwr_addr; n_wr++; end
   end

   task automatic clr();
      {n_st, n_hi, n_pi, n_ri, n_rq, n_wr} = '0;
   endtask : clr
   task automatic wr(input logic [RA_W-1:0] a, input logic [31:0] d);
      @(posedge clk_i); addr <= a; wdata <= d; we <= 1'b1;
      @(posedge clk_i); we <= 1'b0;
   endtask : wr
   task automatic chk_reg(input string n, input logic [RA_W-1:0] a, input logic [31:0] e);
      @(posedge clk_i); addr <= a; re <= 1'b1;
      @(posedge clk_i); re <= 1'b0;
      #1 `CHK(n, e, rdata)
   endtask : chk_reg
   task automatic eof();
      @(posedge clk_i); rsz_eof <= 1'b1;
      @(posedge clk_i); rsz_eof <= 1'b0;
   endtask : eof
   task automatic wait_irq(input logic e);
      int i;
      for (i = 0; i < 20 && irq !== e; i++) @(posedge clk_i);
      `CHK("irq", e, irq)
   endtask : wait_irq

   task automatic test_regs();
      chk_reg("ctrl", OFF_CTRL, {22'h0, CTRL_RESET});
      chk_reg("ratio", OFF_RATIO, {21'h0, RATIO_RESET});
      chk_reg("buffers", OFF_BUF_COUNT, {28'h0, BUF_COUNT_RESET});
      chk_reg("mask", OFF_IRQ_MASK, 32'h0);
      wr(8'h40, 32'hFFFF_FFFF);
      chk_reg("unmapped", 8'h40, 32'h0);
      wr(OFF_MEM_IN, 32'h1234_5678);
      chk_reg("mem in", OFF_MEM_IN, 32'h1234_5678);
      $display("test regs done");
   endtask : test_regs

   task automatic test_live();
      logic [RAW_W-1:0] e;
      e = 10'h2A1 + 10'h01C;
      wr(OFF_MEM_IN, 32'h0);
      wr(OFF_CTRL, 32'h0000_0111);
      clr();
      far_u.send_frame(10'h2A1, 5);
      repeat (8) @(posedge clk_i);
      `CHK("stats", 5, n_st)
      `CHK("hist", 5, n_hi)
      `CHK("pipe", 5, n_pi)
      `CHK("resizer in", 5, n_ri)
      `CHK("hist data", e, last_hist)
      `CHK("luma", e[9:2], last_pipe[7:0])
      eof();
      chk_reg("ctrl", OFF_CTRL, 32'h0000_0011);
      $display("test live done");
   endtask : test_live

   task automatic test_ratio();
      logic [31:0] tbl[4] = '{32'h040, 32'h03F, 32'h400, 32'h401};
      int i;
      for (i = 0; i < 4; i++) begin
         wr(OFF_RATIO, tbl[i]);
         wr(OFF_IRQ_STAT, 32'hF);
         wr(OFF_CTRL, 32'h0000_0111);
         chk_reg("ratio error", OFF_IRQ_STAT, i[0] ? 32'h4 : 32'h0);
         chk_reg("ctrl", OFF_CTRL, i[0] ? 32'h011 : 32'h111);
         if (!i[0]) eof();
      end
      wr(OFF_RATIO, 32'h100);
      $display("test ratio done");
   endtask : test_ratio

   task automatic test_two_pass();
      wr(OFF_MEM_IN, 32'h0000_1000);
      wr(OFF_IN_SIZE, 32'h4);
      wr(OFF_IRQ_STAT, 32'hF);
      wr(OFF_IRQ_MASK, 32'h8);
      clr();
      slow <= 1'b1;
      wr(OFF_CTRL, 32'h0000_0351);
      wait_irq(1'b1);
      repeat (4) @(posedge clk_i);
      `CHK("requests", 4, n_rq)
      `CHK("first addr", 32'h0000_1000, first_req)
      `CHK("mem words", 4, n_ri)
      eof();
      chk_reg("status", OFF_STATUS, 32'h4);
      wr(OFF_MEM_IN, 32'h0);
      wr(OFF_CTRL, 32'h0000_0311);
      clr();
      far_u.send_frame(10'h155, 3);
      repeat (8) @(posedge clk_i);
      `CHK("live words", 3, n_ri)
      `CHK("no requests", 0, n_rq)
      eof();
      chk_reg("status", OFF_STATUS, 32'h0);
      wr(OFF_IRQ_MASK, 32'h0);
      slow <= 1'b0;
      $display("test two pass done");
   endtask : test_two_pass

   task automatic test_writer();
      int f, k;
      wr(OFF_OUT_BASE, 32'h0000_2000);
      wr(OFF_STRIDE, 32'h0000_0100);
      wr(OFF_BUF_COUNT, 32'h2);
      wr(OFF_IRQ_STAT, 32'hF);
      for (f = 0; f < 3; f++) begin
         wr(OFF_IRQ_MASK, f == 1 ? 32'h0 : 32'h2);
         wr(OFF_CTRL, 32'h0000_0111);
         clr();
         for (k = 0; k < 2; k++) begin
            @(posedge clk_i); rout_valid <= 1'b1; rout_data <= 16'h0A00 + 16'(k);
         end
         @(posedge clk_i); rout_valid <= 1'b0; rout_data <= ~rout_data;
         eof();
         `CHK("write addr", 32'h2000 + 32'(f % 2) * 32'h100, wr_a[0])
         `CHK("write addr next", 32'h2002 + 32'(f % 2) * 32'h100, wr_a[1])
         wait_irq(f != 1);
         chk_reg("irq status", OFF_IRQ_STAT, 32'h2);
         wr(OFF_IRQ_STAT, 32'h2);
         wait_irq(1'b0);
      end
      $display("test writer done");
   endtask : test_writer

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      stop_test();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      test_regs();
      test_live();
      test_ratio();
      test_two_pass();
      test_writer();
      stop_test();
   end
endmodule : test_cpr_router

bind cpr_router cpr_router_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .stats_data_o(stats_data_o), .stats_valid_o(stats_valid_o), .hist_data_o(hist_data_o),
   .hist_valid_o(hist_valid_o), .pipe_data_o(pipe_data_o), .pipe_valid_o(pipe_valid_o),
   .rsz_in_data_o(rsz_in_data_o), .rsz_in_valid_o(rsz_in_valid_o), .mrd_req_o(mrd_req_o),
   .mrd_addr_o(mrd_addr_o), .mrd_data_i(mrd_data_i), .mrd_valid_i(mrd_valid_i),
   .mwr_valid_o(mwr_valid_o), .mwr_addr_o(mwr_addr_o));
